// [rtl/afm_pkg.sv]
package afm_pkg;
    // Threshold reset values
    localparam logic [15:0] AFM_SHUNT_LOWER_RST = 16'h8000;
    localparam logic [15:0] AFM_SHUNT_UPPER_RST = 16'h7fff;
    localparam logic [15:0] AFM_BUS_UPPER_RST = 16'h7fff;
    localparam logic [15:0] AFM_BUS_LOWER_RST = 16'h0000;
    localparam logic [15:0] AFM_HEAT_RST = 16'hffff;
    localparam logic [15:0] AFM_POWER_UPPER_RST = 16'h7fff;
    // Register select codes on the local register port
    localparam logic [3:0] AFM_REG_SHUNT_LOWER = 4'h0;
    localparam logic [3:0] AFM_REG_SHUNT_UPPER = 4'h1;
    localparam logic [3:0] AFM_REG_BUS_UPPER = 4'h2;
    localparam logic [3:0] AFM_REG_BUS_LOWER = 4'h3;
    localparam logic [3:0] AFM_REG_HEAT = 4'h4;
    localparam logic [3:0] AFM_REG_POWER_UPPER = 4'h5;
    localparam logic [3:0] AFM_REG_DIAG = 4'h6;
    localparam logic [3:0] AFM_REG_TEMPCO = 4'h7;
    localparam logic [3:0] AFM_REG_ADC_CFG = 4'h8;
    localparam logic [3:0] AFM_REG_CFG = 4'h9;
    // Diagnostic status bit positions
    localparam int AFM_B_LATCH = 15;
    localparam int AFM_B_READY_EN = 14;
    localparam int AFM_B_AVG_CMP = 13;
    localparam int AFM_B_POL = 12;
    localparam int AFM_B_JOULE_OF = 11;
    localparam int AFM_B_COULOMB_OF = 10;
    localparam int AFM_B_ARITH_OF = 9;
    localparam int AFM_B_HEAT = 7;
    localparam int AFM_B_VBUS_HIGH = 6;
    localparam int AFM_B_VBUS_LOW = 5;
    localparam int AFM_B_SHUNT_HIGH = 4;
    localparam int AFM_B_SHUNT_LOW = 3;
    localparam int AFM_B_WATTS = 2;
    localparam int AFM_B_DONE = 1;
    localparam int AFM_B_MEM_OK = 0;
    // Adc config fields
    localparam int AFM_MODE_LSB = 12;
    localparam int AFM_AVG_LSB = 0;
    localparam logic [3:0] AFM_MODE_SHUTDOWN = 4'h0;
    localparam int AFM_CFG_DRIFT_BIT = 5;
    // Timing
    localparam int AFM_CLK_HZ = 10_000_000;
    localparam int AFM_STABLE_US = 300;
    localparam int AFM_STABLE_CYC = (AFM_STABLE_US * (AFM_CLK_HZ / 1_000_000));
    localparam int AFM_TEMP_REF_C = 25;
    localparam int AFM_PPM = 1_000_000;
endpackage

// [rtl/afm_alert_fault_monitor.sv]
// Function
// R1: Filter settles within one conversion period
// R2: Notch at one over twice period
// R3: Per-channel conversion periods 50us to 4.12ms
// R4: One averaging count, 1 to 1024
// R5: Drift-adjusted resistance when correction enabled
// R6: Coefficient treated as always positive
// R7: Current recomputed with latest die temperature
// R8: One time base for sequencing, elapsed count
// R9: Allow 300us settling after power-up
// R10: Six limit checks set status flags
// R11: Threshold reset defaults and signedness
// R12: Host reads status to find cause
// R13: Latched alert held until status read
// R14: Ready alert on every conversion complete
// R15: Done flag set regardless of enable
// R16: Ready alert in one-shot and continuous
// R17: Averaged comparison uses averaged results
// R18: Open-drain alert, active-low, polarity bit
// R19: Arithmetic overflow flag
// R20: Trim memory flag reads one when intact
// R21: Separate accumulator overflow flags
// R22: Health flags never drive alert
// R23: Done cleared by config write or read
// R24: Unlatched alert follows live conditions
// R25: Unaveraged compare on each sample
`timescale 1ns/10ps
`default_nettype none
module afm_alert_fault_monitor
    import afm_pkg::*;
#(
    parameter int STABLE_CYC = AFM_STABLE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // Results from the measurement engine
    input wire logic sample_valid,
    input wire logic avg_valid,
    input wire logic [15:0] shunt_value,
    input wire logic [15:0] bus_value,
    input wire logic [15:0] heat_value,
    input wire logic [15:0] power_value,
    input wire logic conv_done,
    input wire logic arith_ovf,
    input wire logic joule_ovf,
    input wire logic coulomb_ovf,
    input wire logic trim_ok,
    input wire logic [31:0] r_nominal,
    // Engine controls
    output logic [15:0] adc_cfg,
    output logic drift_correction_enable,
    output logic [15:0] shunt_coefficient_reg,
    output logic [31:0] r_adjusted,
    output logic results_stable,
    // Open-drain alert
    output logic alert_o,
    output logic alert_oe
);
    logic rst_s1;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    logic [15:0] shunt_lower_threshold;
    logic [15:0] shunt_upper_threshold;
    logic [15:0] bus_upper_threshold;
    logic [15:0] bus_lower_threshold;
    logic [15:0] die_heat_threshold;
    logic [15:0] power_upper_threshold;
    logic [15:0] cfg;
    logic latch_enable_bit;
    logic ready_alert_enable;
    logic averaged_compare_bit;
    logic output_polarity_bit;

    function automatic logic hit(input logic [3:0] sel);
        return reg_wr && (reg_sel == sel);
    endfunction

    // Positive-only limits are zero-extended, so the 0xffff heat
    // default never trips, even for negative readings
    function automatic logic pos_above(input logic [15:0] v, input logic [15:0] lim);
        return $signed({v[15], v}) > $signed({1'b0, lim});
    endfunction

    function automatic logic pos_below(input logic [15:0] v, input logic [15:0] lim);
        return $signed({v[15], v}) < $signed({1'b0, lim});
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_lower_threshold <= AFM_SHUNT_LOWER_RST; // R11
            shunt_upper_threshold <= AFM_SHUNT_UPPER_RST; // R11
            bus_upper_threshold <= AFM_BUS_UPPER_RST; // R11
            bus_lower_threshold <= AFM_BUS_LOWER_RST; // R11
            die_heat_threshold <= AFM_HEAT_RST; // R11
            power_upper_threshold <= AFM_POWER_UPPER_RST; // R11
        end else begin
            if (hit(AFM_REG_SHUNT_LOWER)) begin
                shunt_lower_threshold <= reg_wdata;
            end
            if (hit(AFM_REG_SHUNT_UPPER)) begin
                shunt_upper_threshold <= reg_wdata;
            end
            // Bus and heat limits are positive only; sign bit forced low
            if (hit(AFM_REG_BUS_UPPER)) begin
                bus_upper_threshold <= {1'b0, reg_wdata[14:0]}; // R11
            end
            if (hit(AFM_REG_BUS_LOWER)) begin
                bus_lower_threshold <= {1'b0, reg_wdata[14:0]}; // R11
            end
            if (hit(AFM_REG_HEAT)) begin
                die_heat_threshold <= {1'b0, reg_wdata[14:0]}; // R11
            end
            if (hit(AFM_REG_POWER_UPPER)) begin
                power_upper_threshold <= reg_wdata;
            end
        end
    end

    // Coefficient kept as a magnitude; the drift math never signs it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shunt_coefficient_reg <= 16'h0000;
        end else if (hit(AFM_REG_TEMPCO)) begin
            shunt_coefficient_reg <= reg_wdata;
        end
    end

    // Per-channel periods and one shared averaging count live here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_cfg <= 16'h0000;
        end else if (hit(AFM_REG_ADC_CFG)) begin
            adc_cfg <= reg_wdata; // R3 R4
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= 16'h0000;
        end else if (hit(AFM_REG_CFG)) begin
            cfg <= reg_wdata;
        end
    end

    // Control bits share the status word; flag bits ignore writes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_enable_bit <= 1'b0;
            ready_alert_enable <= 1'b0;
            averaged_compare_bit <= 1'b0;
            output_polarity_bit <= 1'b0;
        end else if (hit(AFM_REG_DIAG)) begin
            latch_enable_bit <= reg_wdata[AFM_B_LATCH];
            ready_alert_enable <= reg_wdata[AFM_B_READY_EN];
            averaged_compare_bit <= reg_wdata[AFM_B_AVG_CMP];
            output_polarity_bit <= reg_wdata[AFM_B_POL];
        end
    end
    assign drift_correction_enable = cfg[AFM_CFG_DRIFT_BIT];

    // Filter settling, notch placement and sequencing all follow the one clock
    // given to the engine; this block only forwards the period settings. R1 R2 R8

    // Settling counter after reset
    localparam int CW = $clog2(STABLE_CYC + 1);
    logic [CW-1:0] stable_cnt;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_cnt <= '0;
            results_stable <= 1'b0;
        end else if (!results_stable) begin
            stable_cnt <= stable_cnt + 1'b1;
            results_stable <= (stable_cnt == CW'(STABLE_CYC - 1)); // R9
        end
    end

    // Drift correction, recomputed every cycle from the latest die temperature
    logic signed [17:0] heat_delta;
    logic [47:0] drift_prod;
    logic [31:0] r_extra;
    always_comb begin
        heat_delta = $signed({{2{heat_value[15]}}, heat_value}) - 18'sd25;
        // Negative delta gives no correction: coefficient is positive-only R6
        drift_prod = heat_delta[17] ? 48'h0 :
            48'(r_nominal) * 48'(heat_delta[16:0]) * 48'(shunt_coefficient_reg) / 48'(AFM_PPM);
        r_extra = drift_prod[31:0];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_adjusted <= 32'h0;
        end else begin
            r_adjusted <= drift_correction_enable ? r_nominal + r_extra : r_nominal; // R5 R7
        end
    end

    // Limit comparisons
    logic cmp_strobe;
    logic [5:0] live;
    assign cmp_strobe = averaged_compare_bit ? avg_valid : sample_valid; // R17 R25
    always_comb begin
        live[0] = $signed(shunt_value) < $signed(shunt_lower_threshold);
        live[1] = $signed(shunt_value) > $signed(shunt_upper_threshold);
        live[2] = pos_above(bus_value, bus_upper_threshold);
        live[3] = pos_below(bus_value, bus_lower_threshold);
        live[4] = pos_above(heat_value, die_heat_threshold);
        live[5] = $signed(power_value) > $signed(power_upper_threshold);
    end

    logic [5:0] cond;
    logic shunt_low_flag;
    logic shunt_high_flag;
    logic vbus_high_flag;
    logic vbus_low_flag;
    logic heat_high_flag;
    logic watts_high_flag;
    logic diag_read;
    assign diag_read = reg_rd && (reg_sel == AFM_REG_DIAG);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cond <= 6'h00;
        end else if (cmp_strobe) begin
            cond <= live; // R10
        end
    end
    assign {watts_high_flag, heat_high_flag, vbus_low_flag, vbus_high_flag,
            shunt_high_flag, shunt_low_flag} = cond;

    // Done flag and sticky health flags; a set wins over a read clear
    logic conversion_done_flag;
    logic arith_overflow_flag;
    logic joule_accum_overflow_flag;
    logic coulomb_accum_overflow_flag;
    logic trim_memory_ok_flag;
    logic adc_cfg_clear;
    assign adc_cfg_clear = hit(AFM_REG_ADC_CFG) &&
        (reg_wdata[AFM_MODE_LSB +: 4] != AFM_MODE_SHUTDOWN);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_done_flag <= 1'b0;
        end else if (conv_done) begin
            conversion_done_flag <= 1'b1; // R15 R16
        end else if (diag_read || adc_cfg_clear) begin
            conversion_done_flag <= 1'b0; // R23
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arith_overflow_flag <= 1'b0;
        end else begin
            arith_overflow_flag <= arith_ovf | (arith_overflow_flag & ~diag_read); // R19
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            joule_accum_overflow_flag <= 1'b0;
        end else begin
            joule_accum_overflow_flag <= joule_ovf | (joule_accum_overflow_flag & ~diag_read); // R21
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            coulomb_accum_overflow_flag <= 1'b0;
        end else begin
            coulomb_accum_overflow_flag <= coulomb_ovf | (coulomb_accum_overflow_flag & ~diag_read); // R21
        end
    end

    // Reads low during reset, so a dead trim memory is never masked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trim_memory_ok_flag <= 1'b0;
        end else begin
            trim_memory_ok_flag <= trim_ok; // R20
        end
    end

    // Alert: only limit conditions and conversion-ready, never health flags R22
    logic alert_src;
    logic alert_hold;
    logic alert_active;
    logic ready_req;
    logic live_any;
    // Ready request follows the done flag, so a status read or a
    // non-shutdown config write drops it together with the flag
    assign ready_req = ready_alert_enable & conversion_done_flag; // R14
    assign live_any = |cond;
    assign alert_src = live_any | ready_req;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_hold <= 1'b0;
        end else if (alert_src && latch_enable_bit) begin
            alert_hold <= 1'b1; // R13
        end else if (diag_read || !latch_enable_bit) begin
            alert_hold <= 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alert_active <= 1'b0;
        end else begin
            alert_active <= latch_enable_bit ? (alert_src | alert_hold) // R13
                : alert_src; // R24
        end
    end
    // Open-drain: drive low only; a pull-up provides the high level R18
    assign alert_o = 1'b0;
    assign alert_oe = alert_active ^ output_polarity_bit; // R18

    // Status read
    logic [15:0] diag_word;
    always_comb begin
        diag_word = 16'h0000;
        diag_word[AFM_B_LATCH] = latch_enable_bit;
        diag_word[AFM_B_READY_EN] = ready_alert_enable;
        diag_word[AFM_B_AVG_CMP] = averaged_compare_bit;
        diag_word[AFM_B_POL] = output_polarity_bit;
        diag_word[AFM_B_JOULE_OF] = joule_accum_overflow_flag;
        diag_word[AFM_B_COULOMB_OF] = coulomb_accum_overflow_flag;
        diag_word[AFM_B_ARITH_OF] = arith_overflow_flag;
        diag_word[AFM_B_HEAT] = heat_high_flag;
        diag_word[AFM_B_VBUS_HIGH] = vbus_high_flag;
        diag_word[AFM_B_VBUS_LOW] = vbus_low_flag;
        diag_word[AFM_B_SHUNT_HIGH] = shunt_high_flag;
        diag_word[AFM_B_SHUNT_LOW] = shunt_low_flag;
        diag_word[AFM_B_WATTS] = watts_high_flag;
        diag_word[AFM_B_DONE] = conversion_done_flag;
        diag_word[AFM_B_MEM_OK] = trim_memory_ok_flag;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_sel)
                AFM_REG_SHUNT_LOWER: reg_rdata <= shunt_lower_threshold;
                AFM_REG_SHUNT_UPPER: reg_rdata <= shunt_upper_threshold;
                AFM_REG_BUS_UPPER: reg_rdata <= bus_upper_threshold;
                AFM_REG_BUS_LOWER: reg_rdata <= bus_lower_threshold;
                AFM_REG_HEAT: reg_rdata <= die_heat_threshold;
                AFM_REG_POWER_UPPER: reg_rdata <= power_upper_threshold;
                AFM_REG_DIAG: reg_rdata <= diag_word; // R12
                AFM_REG_TEMPCO: reg_rdata <= shunt_coefficient_reg;
                AFM_REG_ADC_CFG: reg_rdata <= adc_cfg;
                AFM_REG_CFG: reg_rdata <= cfg;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule
`default_nettype wire

// [verification/afm_alert_fault_monitor_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module afm_alert_fault_monitor_chk
    import afm_pkg::*;
#(
    parameter int STABLE_CYC = AFM_STABLE_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [3:0] reg_sel,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic conv_done,
    input wire logic trim_ok,
    input wire logic [15:0] shunt_coefficient_reg,
    input wire logic alert_o,
    input wire logic alert_oe
);
    // Shadow of latch, ready and polarity bits, so pin checks follow the setup
    logic [2:0] ctl;
    wire logic diag_rd = reg_rd && (reg_sel == AFM_REG_DIAG);
    wire logic act = alert_oe ^ ctl[0];
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl <= 3'h0;
        end else if (reg_wr && (reg_sel == AFM_REG_DIAG)) begin
            ctl <= {reg_wdata[AFM_B_LATCH], reg_wdata[AFM_B_READY_EN], reg_wdata[AFM_B_POL]};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_od_low;
        alert_o == 1'b0;
    endproperty
    a_od_low: assert property (p_od_low) else $error("alert pin driven high");
    property p_mem;
        diag_rd && $stable(trim_ok) |=> reg_rdata[AFM_B_MEM_OK] == $past(trim_ok);
    endproperty
    a_mem: assert property (p_mem) else $error("trim flag wrong");
    property p_done_bit;
        conv_done ##1 !(reg_wr || diag_rd) [*3] ##1 diag_rd |=> reg_rdata[AFM_B_DONE];
    endproperty
    a_done_bit: assert property (p_done_bit) else $error("done flag not set");
    property p_done_clr;
        (diag_rd && !conv_done) ##1 !conv_done ##1 (diag_rd && !conv_done) |=> !reg_rdata[AFM_B_DONE];
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done flag not cleared by read");
    property p_ready;
        (conv_done && ctl[1]) ##1 !(reg_wr || diag_rd) |-> ##1 act;
    endproperty
    a_ready: assert property (p_ready) else $error("no ready alert");
    property p_latch;
        ctl[2] && act && !diag_rd && !$past(diag_rd) && !reg_wr && !$past(reg_wr) |=> act;
    endproperty
    a_latch: assert property (p_latch) else $error("latched alert dropped");
    property p_bus_pos;
        reg_rd && (reg_sel == AFM_REG_BUS_UPPER || reg_sel == AFM_REG_BUS_LOWER) |=> !reg_rdata[15];
    endproperty
    a_bus_pos: assert property (p_bus_pos) else $error("bus limit negative");
    property p_coef;
        reg_wr && (reg_sel == AFM_REG_TEMPCO) |=> shunt_coefficient_reg == $past(reg_wdata);
    endproperty
    a_coef: assert property (p_coef) else $error("coefficient not taken");
    c_ready: cover property (conv_done && ctl[1]);
    c_latch: cover property (ctl[2] && act);
    c_pol: cover property (ctl[0] && act);
endmodule
bind afm_alert_fault_monitor afm_alert_fault_monitor_chk #(.STABLE_CYC(STABLE_CYC)) chk_u (
    .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .trim_ok(trim_ok),
    .shunt_coefficient_reg(shunt_coefficient_reg), .alert_o(alert_o), .alert_oe(alert_oe)
);
`default_nettype wire

// [verification/afm_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module afm_host_model (
    input wire logic clk,
    input wire logic [15:0] reg_rdata,
    input wire logic alert_o,
    input wire logic alert_oe,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_sel,
    output logic [15:0] reg_wdata,
    output logic alert_pin
);
    // Board pull-up wins whenever nobody sinks the line
    assign alert_pin = alert_oe ? alert_o : 1'b1;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_sel = 4'hf;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [3:0] s, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_sel = s;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] s, output logic [15:0] d);
        @(posedge clk);
        #1;
        reg_sel = s;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// [verification/test_alert_fault_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module test_alert_fault_monitor;
    import afm_pkg::*;
    localparam logic [63:0] OK_V = {16'h0000, 16'd500, 16'd25, 16'd10};
    localparam logic [63:0] HOT_V = {16'h0000, 16'd500, 16'd150, 16'd10};
    logic clk;
    logic rstn;
    logic trim_ok;
    logic [5:0] ev;
    logic [15:0] shunt_value, bus_value, heat_value, power_value, rdv, reg_rdata, reg_wdata, adc_cfg, tco;
    logic [31:0] r_nominal, r_adjusted, rp;
    logic [3:0] reg_sel;
    logic reg_wr, reg_rd, drift_correction_enable, results_stable, alert_o, alert_oe, alert_pin;
    int fail_count = 0;
    int checks_done = 0;
    afm_alert_fault_monitor #(.STABLE_CYC(10)) dut_u (
        .clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_valid(ev[0]), .avg_valid(ev[1]), .shunt_value(shunt_value),
        .bus_value(bus_value), .heat_value(heat_value), .power_value(power_value), .conv_done(ev[2]),
        .arith_ovf(ev[3]), .joule_ovf(ev[4]), .coulomb_ovf(ev[5]), .trim_ok(trim_ok), .r_nominal(r_nominal),
        .adc_cfg(adc_cfg), .drift_correction_enable(drift_correction_enable), .shunt_coefficient_reg(tco),
        .r_adjusted(r_adjusted), .results_stable(results_stable), .alert_o(alert_o), .alert_oe(alert_oe)
    );
    afm_host_model host_u (
        .clk(clk), .reg_rdata(reg_rdata), .alert_o(alert_o), .alert_oe(alert_oe), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .alert_pin(alert_pin)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Results change with the strobe; two more edges let flag and pin settle
    task automatic fire(input logic [63:0] v, input logic [5:0] m);
        @(posedge clk);
        #1;
        {shunt_value, bus_value, heat_value, power_value} = v;
        ev = m;
        @(posedge clk);
        #1;
        ev = 6'h00;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_defaults;
        logic [15:0] dv [6] = '{16'h8000, 16'h7fff, 16'h7fff, 16'h0000, 16'hffff, 16'h7fff};
        chk(results_stable, 1'b0);
        for (int i = 0; i < 6; i++) begin
            host_u.rd(i[3:0], rdv);
            chk(rdv, dv[i]);
        end
        host_u.rd(4'hc, rdv);
        chk(rdv, 16'h0000);
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[AFM_B_MEM_OK], 1'b1);
        chk(results_stable, 1'b1);
        chk(alert_pin, 1'b1);
        host_u.wr(AFM_REG_BUS_UPPER, 16'hffff);
        host_u.rd(AFM_REG_BUS_UPPER, rdv);
        chk(rdv, 16'h7fff);
    endtask
    task automatic t_limits;
        logic [15:0] th [6] = '{16'hff9c, 16'd100, 16'd1000, 16'd100, 16'd100, 16'd1000};
        logic [15:0] val [6] = '{16'hff38, 16'd200, 16'd2000, 16'd50, 16'd150, 16'd2000};
        int fld [6] = '{0, 0, 1, 1, 2, 3};
        int bn [6] = '{3, 4, 6, 5, 7, 2};
        logic [63:0] v;
        for (int i = 0; i < 6; i++) begin
            host_u.wr(i[3:0], th[i]);
        end
        for (int i = 0; i < 6; i++) begin
            v = OK_V;
            v[63 - 16 * fld[i] -: 16] = val[i];
            fire(v, 6'h01);
            chk(alert_pin, 1'b0);
            host_u.rd(AFM_REG_DIAG, rdv);
            chk(rdv[bn[i]], 1'b1);
            fire(OK_V, 6'h01);
            chk(alert_pin, 1'b1);
        end
    endtask
    task automatic t_modes;
        host_u.wr(AFM_REG_DIAG, 16'h2000);
        fire(HOT_V, 6'h01);
        chk(alert_pin, 1'b1);
        fire(HOT_V, 6'h02);
        chk(alert_pin, 1'b0);
        host_u.wr(AFM_REG_DIAG, 16'h8000);
        fire(HOT_V, 6'h01);
        fire(OK_V, 6'h01);
        chk(alert_pin, 1'b0);
        host_u.rd(AFM_REG_DIAG, rdv);
        repeat (2) @(posedge clk);
        #1;
        chk(alert_pin, 1'b1);
        host_u.wr(AFM_REG_DIAG, 16'h1000);
        chk(alert_pin, 1'b0);
        fire(HOT_V, 6'h01);
        chk(alert_pin, 1'b1);
        fire(OK_V, 6'h01);
        host_u.wr(AFM_REG_DIAG, 16'h0000);
    endtask
    task automatic t_ready;
        logic [3:0] mode [2] = '{4'h1, 4'hf};
        fire(OK_V, 6'h04);
        chk(alert_pin, 1'b1);
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[AFM_B_DONE], 1'b1);
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[AFM_B_DONE], 1'b0);
        host_u.wr(AFM_REG_DIAG, 16'h4000);
        for (int j = 0; j < 2; j++) begin
            host_u.wr(AFM_REG_ADC_CFG, {mode[j], 12'h003});
            chk(adc_cfg, {mode[j], 12'h003});
            fire(OK_V, 6'h04);
            chk(alert_pin, 1'b0);
            host_u.wr(AFM_REG_ADC_CFG, 16'h0003);
            chk(alert_pin, 1'b0);
            host_u.wr(AFM_REG_ADC_CFG, {mode[j], 12'h003});
            repeat (2) @(posedge clk);
            #1;
            chk(alert_pin, 1'b1);
        end
    endtask
    task automatic t_health;
        fire(OK_V, 6'h38);
        chk(alert_pin, 1'b1);
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[11:9], 3'h7);
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[11:9], 3'h0);
        trim_ok = 1'b0;
        host_u.rd(AFM_REG_DIAG, rdv);
        chk(rdv[AFM_B_MEM_OK], 1'b0);
        chk(alert_pin, 1'b1);
        trim_ok = 1'b1;
    endtask
    task automatic t_drift;
        host_u.wr(AFM_REG_CFG, 16'h0020);
        chk(drift_correction_enable, 1'b1);
        host_u.wr(AFM_REG_TEMPCO, 16'd4000);
        chk(tco, 16'd4000);
        fire(OK_V, 6'h01);
        chk(r_adjusted, 32'd1000000);
        fire({16'h0000, 16'd500, 16'd10, 16'd10}, 6'h01);
        chk(r_adjusted, 32'd1000000);
        fire({16'h0000, 16'd500, 16'd60, 16'd10}, 6'h01);
        chk(r_adjusted > 32'd1000000, 1'b1);
        rp = r_adjusted;
        fire({16'h0000, 16'd500, 16'd90, 16'd10}, 6'h01);
        chk(r_adjusted > rp, 1'b1);
    endtask
    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        rstn = 1'b0;
        ev = 6'h00;
        trim_ok = 1'b1;
        r_nominal = 32'd1000000;
        {shunt_value, bus_value, heat_value, power_value} = OK_V;
        repeat (20) @(posedge clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        t_defaults();
        t_limits();
        t_modes();
        t_ready();
        t_health();
        t_drift();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
